// *** hdl/ddp_data_path.sv ***
// Overview of operation
// - Disk address bits 3:0 hold the sector, 0 up to octal 13.
// - Each count-sector pulse advances the disk address to the next sector.
// - Last-sector with count-sector raises change-heads and toggles surface bit 4.
// - Surface wraps to zero after lower surface and cylinder field increments.
// - Bits 12:5 are the cylinder up to octal 312; bits 15:13 pick drive.
// - Init clears bits 15:4; sector bits clear on init or change-heads.
// - Bus address loads by byte strobes, counts by two, clears on init.
// - Transfer-complete adds two to bus address unless inhibit bit is set.
// - Input buffer loads on bus strobe in writes, shifts per bit in reads.
// - Format-mode read shifts the input buffer only during the header.
// - Input-full sets on last read bit or transfer end; file write clears it.
// - Bit counter counts shifts, flags last bit, restarts on next shift.
// - Transfer enable sets on new function, clears on count overflow or stop.
// - Output buffer shifts per write clock bit and loads from the file.
// - Output-full sets on read-done, clears on last bit, transfer end, clear.
// - Data-late sets on overrun or underrun of the buffers; init clears it.
// - File not empty and output empty: load output buffer, then read-done.
// - File not full and input full: write file, then write-done.
// - Two-bit file pointers and occupancy flags give file full and empty.
// - With enable, request bus transfer per buffer state; never in read-check.
// - Count-sector fires when sector-end drops; last-word-done raises it.
// - Cylinder overflow on change-heads with surface set and file not done.
// - Read bit enters the top bit of the input buffer.
`timescale 1ns/1ps
`include "ddp_defines.svh"

module ddp_file import ddp_pkg::*; #(
	parameter int WIDTH = `DDP_W_NARROW,
	parameter int DEPTH = `DDP_FIFO_DEPTH
) (
	// Clock and control
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic clear,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wp_q, rp_q;
	logic [DEPTH-1:0] occ_q, occ_d;
	logic push, pop;

	assign in_ready = ~&occ_q;
	assign out_valid = |occ_q;
	assign out_data = mem_q[rp_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wp_q <= '0;
			rp_q <= '0;
		end else if (ce) begin
			if (clear) begin
				wp_q <= '0;
				rp_q <= '0;
			end else begin
				if (push) begin
					wp_q <= PW'(wp_q + 1'b1);
				end
				if (pop) begin
					rp_q <= PW'(rp_q + 1'b1);
				end
			end
		end
	end

	always_comb begin
		occ_d = occ_q;
		for (int i = 0; i < DEPTH; i++) begin
			if (pop && rp_q == PW'(i)) begin
				occ_d[i] = 1'b0;
			end
			if (push && wp_q == PW'(i)) begin
				occ_d[i] = 1'b1;
			end
		end
		if (clear) begin
			occ_d = '0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			occ_q <= '0;
		end else if (ce) begin
			occ_q <= occ_d;
		end
	end
endmodule // ddp_file

module ddp_data_path import ddp_pkg::*; #(
	parameter bit WIDE = 1'b0
) (
	// Clock, enable, reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// Clears
	input wire logic init,
	input wire logic general_clear,
	// Function and control bits
	input wire logic func_read,
	input wire logic func_read_check,
	input wire logic func_write,
	input wire logic func_write_check,
	input wire logic format_mode,
	input wire logic inhibit_address_increment,
	input wire logic new_function,
	input wire logic word_count_overflow,
	input wire logic stop_transfers,
	// Bus side
	input wire logic [(WIDE ? 18 : 16)-1:0] bus_data,
	input wire logic bus_data_strobe,
	input wire logic transfer_complete_pulse,
	input wire logic disk_address_load_low,
	input wire logic disk_address_load_high,
	input wire logic bus_address_load_low,
	input wire logic bus_address_load_high,
	// Disk control side
	input wire logic data_major,
	input wire logic header_major,
	input wire logic last_sector,
	input wire logic last_word_done,
	input wire logic file_done,
	input wire logic drive_read_clock,
	input wire logic write_clock,
	input wire logic ser_rd_data,
	// Registers and buffers
	output logic [15:0] disk_address_q,
	output logic [15:0] bus_address_q,
	output logic [(WIDE ? 18 : 16)-1:0] out_buffer_q,
	// Flags and strobes
	output logic data_late_error_q,
	output logic transfer_enable_q,
	output logic transfer_request_q,
	output logic input_buffer_full_q,
	output logic output_buffer_full_q,
	output logic count_sector_pulse_q,
	output logic change_heads_q,
	output logic cylinder_overflow_q
);
	localparam int W = WIDE ? `DDP_W_WIDE : `DDP_W_NARROW;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic rck1_q, rck2_q, rck3_q, wck1_q, wck2_q, wck3_q, ser1_q, ser2_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{rck1_q, rck2_q, rck3_q} <= 3'h0;
			{wck1_q, wck2_q, wck3_q} <= 3'h0;
			{ser1_q, ser2_q} <= 2'h0;
		end else if (ce) begin
			{rck1_q, rck2_q, rck3_q} <= {drive_read_clock, rck1_q, rck2_q};
			{wck1_q, wck2_q, wck3_q} <= {write_clock, wck1_q, wck2_q};
			{ser1_q, ser2_q} <= {ser_rd_data, ser1_q};
		end
	end

	// ****************************************
	// Shift conditions
	// ****************************************
	logic wr_any, rd_any, shift_in, shift_out, last_bit;
	logic [4:0] bit_cnt_q;
	logic fifo_full, fifo_empty, fifo_in_ready, fifo_out_valid;
	logic [W-1:0] in_buffer_q, fifo_data;
	ddp_seq_t wseq_q, rseq_q;

	assign wr_any = func_write | func_write_check;
	assign rd_any = func_read | func_read_check;
	// Header bits only in format mode
	assign shift_in = func_read & rck2_q & ~rck3_q &
		((data_major & ~format_mode) | (header_major & format_mode));
	assign shift_out = wr_any & wck2_q & ~wck3_q & data_major;
	assign last_bit = bit_cnt_q == 5'(W - 1);
	assign fifo_full = ~fifo_in_ready;
	assign fifo_empty = ~fifo_out_valid;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bit_cnt_q <= 5'h00;
		end else if (ce) begin
			if (general_clear) begin
				bit_cnt_q <= 5'h00;
			end else if (shift_in || shift_out) begin
				bit_cnt_q <= last_bit ? 5'h00 : 5'(bit_cnt_q + 1'b1);
			end
		end
	end

	// ****************************************
	// Input buffer
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			in_buffer_q <= '0;
		end else if (ce) begin
			if (general_clear) begin
				in_buffer_q <= '0;
			end else if (bus_data_strobe && wr_any) begin
				in_buffer_q <= bus_data;
			end else if (shift_in) begin
				in_buffer_q <= {ser2_q, in_buffer_q[W-1:1]};
			end
		end
	end

	// Input full, set wins over clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			input_buffer_full_q <= 1'b0;
		end else if (ce) begin
			if ((shift_in && last_bit) || (transfer_complete_pulse && wr_any)) begin
				input_buffer_full_q <= 1'b1;
			end else if (wseq_q == SEQ_DONE || general_clear) begin
				input_buffer_full_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Four-word file
	// ****************************************
	ddp_file #(
		.WIDTH(W),
		.DEPTH(`DDP_FILE_DEPTH)
	) u_file (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.clear(general_clear),
		.in_valid(wseq_q == SEQ_STROBE),
		.in_ready(fifo_in_ready),
		.in_data(in_buffer_q),
		.out_valid(fifo_out_valid),
		.out_ready(rseq_q == SEQ_STROBE),
		.out_data(fifo_data)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wseq_q <= SEQ_IDLE;
		end else if (ce) begin
			case (wseq_q)
				SEQ_IDLE: begin
					if (input_buffer_full_q && !fifo_full && !general_clear) begin
						wseq_q <= SEQ_STROBE;
					end
				end
				SEQ_STROBE: wseq_q <= SEQ_DONE;
				default: wseq_q <= SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rseq_q <= SEQ_IDLE;
		end else if (ce) begin
			case (rseq_q)
				SEQ_IDLE: begin
					if (!fifo_empty && !output_buffer_full_q && !general_clear) begin
						rseq_q <= SEQ_STROBE;
					end
				end
				SEQ_STROBE: rseq_q <= SEQ_DONE;
				default: rseq_q <= SEQ_IDLE;
			endcase
		end
	end

	// ****************************************
	// Output buffer
	// ****************************************
	logic tcp_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_buffer_q <= '0;
			tcp_q <= 1'b0;
		end else if (ce) begin
			tcp_q <= transfer_complete_pulse;
			// Load from file, else shift toward bit 0
			if (rseq_q == SEQ_STROBE) begin
				out_buffer_q <= fifo_data;
			end else if (shift_out) begin
				out_buffer_q <= {1'b0, out_buffer_q[W-1:1]};
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			output_buffer_full_q <= 1'b0;
		end else if (ce) begin
			if (rseq_q == SEQ_DONE) begin
				output_buffer_full_q <= 1'b1;
			end else if (general_clear || (shift_out && last_bit) ||
				(func_read && tcp_q && !transfer_complete_pulse)) begin
				output_buffer_full_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			data_late_error_q <= 1'b0;
		end else if (ce) begin
			if ((shift_in && input_buffer_full_q) || (shift_out && !output_buffer_full_q)) begin
				data_late_error_q <= 1'b1;
			end else if (init) begin
				data_late_error_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Bus transfer requests
	// ****************************************
	// Transfer enable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			transfer_enable_q <= 1'b0;
		end else if (ce) begin
			if (new_function) begin
				transfer_enable_q <= 1'b1;
			end else if (word_count_overflow || stop_transfers) begin
				transfer_enable_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			transfer_request_q <= 1'b0;
		end else if (ce) begin
			transfer_request_q <= transfer_enable_q &
				((wr_any & ~input_buffer_full_q) | (func_read & output_buffer_full_q));
		end
	end

	// ****************************************
	// Sector sequencing
	// ****************************************
	logic sector_end_q, se_drop, ch_now;

	assign se_drop = (rd_any & fifo_empty & ~output_buffer_full_q) |
		(wr_any & fifo_full & input_buffer_full_q) | ~transfer_enable_q;
	assign ch_now = count_sector_pulse_q & last_sector;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sector_end_q <= 1'b0;
			count_sector_pulse_q <= 1'b0;
		end else if (ce) begin
			sector_end_q <= last_word_done | (sector_end_q & ~se_drop);
			count_sector_pulse_q <= sector_end_q & se_drop & ~last_word_done;
		end
	end

	// Change heads and cylinder overflow strobes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			change_heads_q <= 1'b0;
			cylinder_overflow_q <= 1'b0;
		end else if (ce) begin
			change_heads_q <= ch_now;
			cylinder_overflow_q <= ch_now & disk_address_q[`DDP_SUR_BIT] & ~file_done;
		end
	end

	// ****************************************
	// Disk address register
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			disk_address_q <= `DDP_DA_RST;
		end else if (ce) begin
			if (init) begin
				disk_address_q <= `DDP_DA_RST;
			// Byte loads set sector, surface, cylinder and drive
			end else if (disk_address_load_low || disk_address_load_high) begin
				if (disk_address_load_low) begin
					disk_address_q[7:0] <= bus_data[7:0];
				end
				if (disk_address_load_high) begin
					disk_address_q[15:8] <= bus_data[15:8];
				end
			end else if (ch_now) begin
				disk_address_q[`DDP_SEC_MSB:`DDP_SEC_LSB] <= 4'h0;
				disk_address_q[`DDP_CYL_MSB:`DDP_SUR_BIT] <=
					9'(disk_address_q[`DDP_CYL_MSB:`DDP_SUR_BIT] + 1'b1);
			end else if (count_sector_pulse_q) begin
				disk_address_q[`DDP_SEC_MSB:`DDP_SEC_LSB] <=
					4'(disk_address_q[`DDP_SEC_MSB:`DDP_SEC_LSB] + 1'b1);
			end
		end
	end

	// ****************************************
	// Bus address register
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus_address_q <= `DDP_BA_RST;
		end else if (ce) begin
			// Clear, byte loads, count by two
			if (init) begin
				bus_address_q <= `DDP_BA_RST;
			end else if (bus_address_load_low || bus_address_load_high) begin
				if (bus_address_load_low) begin
					bus_address_q[7:0] <= bus_data[7:0];
				end
				if (bus_address_load_high) begin
					bus_address_q[15:8] <= bus_data[15:8];
				end
			end else if (transfer_complete_pulse && !inhibit_address_increment) begin
				bus_address_q <= 16'(bus_address_q + `DDP_BA_STEP);
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	logic no_da_load;
	assign no_da_load = ~init & ~disk_address_load_low & ~disk_address_load_high;

	a_sector_advance: assert property (
		ce && count_sector_pulse_q && !last_sector && no_da_load |=>
		disk_address_q[3:0] == 4'($past(disk_address_q[3:0]) + 1'b1))
		else $error("sector did not advance");
	a_heads_change: assert property (
		ce && count_sector_pulse_q && last_sector && no_da_load |=>
		change_heads_q && disk_address_q[4] != $past(disk_address_q[4]) &&
		disk_address_q[3:0] == 4'h0)
		else $error("heads did not change");
	a_cyl_overflow: assert property (
		ce && ch_now && disk_address_q[4] && !file_done |=> cylinder_overflow_q)
		else $error("cylinder overflow missing");
	a_addr_step: assert property (
		ce && transfer_complete_pulse && !inhibit_address_increment && !init &&
		!bus_address_load_low && !bus_address_load_high |=>
		bus_address_q == $past(bus_address_q) + 16'h0002)
		else $error("bus address step wrong");
	a_late_read: assert property (
		ce && shift_in && input_buffer_full_q |=> data_late_error_q)
		else $error("data late not flagged");
	a_no_rchk_req: assert property (
		ce && func_read_check && !func_read && !wr_any |=> !transfer_request_q)
		else $error("request during read check");
	a_file_write: assert property (
		ce && wseq_q == SEQ_STROBE ##1 ce |=> !input_buffer_full_q ||
		$past(shift_in) || $past(transfer_complete_pulse))
		else $error("input buffer not emptied");
	a_enable_set: assert property (
		ce && new_function |=> transfer_enable_q)
		else $error("transfer enable not set");
	a_count_pulse: assert property (
		count_sector_pulse_q |-> $past(sector_end_q) && !sector_end_q)
		else $error("count pulse without sector end drop");

	c_change_heads: cover property (change_heads_q);
	c_file_full: cover property (fifo_full && input_buffer_full_q);
	c_data_late: cover property (data_late_error_q);
	c_request: cover property (transfer_request_q ##1 transfer_complete_pulse);
endmodule // ddp_data_path

// *** hdl/ddp_defines.svh ***
`ifndef DDP_DEFINES_SVH
`define DDP_DEFINES_SVH

// ****************************************
// Disk address field layout
// ****************************************
`define DDP_SEC_LSB 0
`define DDP_SEC_MSB 3
`define DDP_SUR_BIT 4
`define DDP_CYL_LSB 5
`define DDP_CYL_MSB 12
`define DDP_DRV_LSB 13
`define DDP_DRV_MSB 15
`define DDP_SEC_MAX 4'hB
`define DDP_CYL_MAX 8'hCA

// ****************************************
// Reset values, steps, depths and widths
// ****************************************
`define DDP_DA_RST 16'h0000
`define DDP_BA_RST 16'h0000
`define DDP_BA_STEP 16'h0002
`define DDP_FILE_DEPTH 4
`define DDP_FIFO_DEPTH 8
`define DDP_W_NARROW 16
`define DDP_W_WIDE 18

`endif

// *** hdl/ddp_pkg.sv ***
package ddp_pkg;

	// File transfer sequence: strobe, then done
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_STROBE = 2'b01,
		SEQ_DONE = 2'b10
	} ddp_seq_t;

endpackage

// *** tb/ddp_data_path_tb.sv ***
`timescale 1ns/1ps
module ddp_data_path_tb;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, init = 1'b0, general_clear = 1'b0;
	logic func_read = 1'b0, func_read_check = 1'b0, func_write = 1'b0, func_write_check = 1'b0;
	logic format_mode = 1'b0, inhibit_address_increment = 1'b0, new_function = 1'b0;
	logic word_count_overflow = 1'b0, stop_transfers = 1'b0, bus_data_strobe = 1'b0;
	logic transfer_complete_pulse = 1'b0, disk_address_load_low = 1'b0;
	logic disk_address_load_high = 1'b0, bus_address_load_low = 1'b0, bus_address_load_high = 1'b0;
	logic data_major = 1'b0, header_major = 1'b0, last_sector = 1'b0, last_word_done = 1'b0;
	logic file_done = 1'b0, rd_go = 1'b0, wr_go = 1'b0;
	logic drive_read_clock, write_clock, ser_rd_data, busy;
	logic [4:0] nbits = 5'h10;
	logic [15:0] bus_data = 16'h0000, rd_word = 16'h0000;
	logic [15:0] disk_address_q, bus_address_q, out_buffer_q;
	logic data_late_error_q, transfer_enable_q, transfer_request_q, input_buffer_full_q;
	logic output_buffer_full_q, count_sector_pulse_q, change_heads_q, cylinder_overflow_q;
	int fail_count = 0, checks = 0, ch_n = 0, cy_n = 0;

	always #2 clk = ~clk;

	// One-cycle strobes are counted off the sampling edge
	always @(negedge clk) begin
		if (change_heads_q === 1'b1) ch_n++;
		if (cylinder_overflow_q === 1'b1) cy_n++;
	end

	ddp_data_path dut_u (.clk, .rstn, .ce, .init, .general_clear, .func_read, .func_read_check,
		.func_write, .func_write_check, .format_mode, .inhibit_address_increment, .new_function,
		.word_count_overflow, .stop_transfers, .bus_data, .bus_data_strobe,
		.transfer_complete_pulse, .disk_address_load_low, .disk_address_load_high,
		.bus_address_load_low, .bus_address_load_high, .data_major, .header_major, .last_sector,
		.last_word_done, .file_done, .drive_read_clock, .write_clock, .ser_rd_data,
		.disk_address_q, .bus_address_q, .out_buffer_q, .data_late_error_q, .transfer_enable_q,
		.transfer_request_q, .input_buffer_full_q, .output_buffer_full_q, .count_sector_pulse_q,
		.change_heads_q, .cylinder_overflow_q);

	ddp_disk_model model_u (.clk, .rd_go, .wr_go, .nbits, .rd_word, .drive_read_clock,
		.write_clock, .ser_rd_data, .busy);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
			fail_count++;
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask

	function automatic logic seen(input int sel);
		case (sel)
			0: return count_sector_pulse_q;
			1: return transfer_request_q;
			2: return output_buffer_full_q;
			default: return !busy;
		endcase
	endfunction

	// Returns on the rising edge after the condition was seen
	task automatic wait_for(input int sel);
		int n;
		for (n = 0; n < 3000; n++) begin
			@(negedge clk);
			if (seen(sel) === 1'b1) break;
		end
		if (n == 3000) begin
			$display("wrong value at %0t: wait %0d got %h, expected %h", $time, sel, 1'b0, 1'b1);
			fail_count++;
			end_of_test();
		end
		@(posedge clk);
	endtask

	// Strobe selectors for pulse
	localparam int S_INIT = 0, S_GCLR = 1, S_NEWF = 2, S_WCO = 3, S_STOP = 4;
	localparam int S_DSTR = 5, S_TCP = 6, S_LWD = 7, S_RDGO = 8, S_WRGO = 9;

	task automatic set_strobe(input int sel, input logic v);
		case (sel)
			S_INIT: init <= v;
			S_GCLR: general_clear <= v;
			S_NEWF: new_function <= v;
			S_WCO: word_count_overflow <= v;
			S_STOP: stop_transfers <= v;
			S_DSTR: bus_data_strobe <= v;
			S_TCP: transfer_complete_pulse <= v;
			S_LWD: last_word_done <= v;
			S_RDGO: rd_go <= v;
			default: wr_go <= v;
		endcase
	endtask

	task automatic pulse(input int sel);
		set_strobe(sel, 1'b1);
		@(posedge clk);
		set_strobe(sel, 1'b0);
		@(posedge clk);
	endtask

	task automatic run_bits(input logic rd, input logic [4:0] n, input logic [15:0] w);
		nbits <= n;
		rd_word <= w;
		if (rd) begin
			pulse(S_RDGO);
		end else begin
			pulse(S_WRGO);
		end
		wait_for(3);
	endtask

	task automatic sector(input logic [15:0] da, input logic last, input logic [15:0] exp,
		input logic ch, input logic cy);
		int c0, y0;
		c0 = ch_n;
		y0 = cy_n;
		bus_data <= da;
		last_sector <= last;
		disk_address_load_low <= 1'b1;
		disk_address_load_high <= 1'b1;
		@(posedge clk);
		disk_address_load_low <= 1'b0;
		disk_address_load_high <= 1'b0;
		pulse(S_NEWF);
		@(negedge clk);
		chk1(transfer_enable_q, 1'b1);
		@(posedge clk);
		pulse(S_LWD);
		pulse(S_STOP);
		wait_for(0);
		repeat (4) @(negedge clk);
		chk(disk_address_q, exp);
		chk1(ch_n != c0, ch);
		chk1(cy_n != y0, cy);
		chk1(transfer_enable_q, 1'b0);
		@(posedge clk);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk(disk_address_q, 16'h0000);
		chk(bus_address_q, 16'h0000);
		@(posedge clk);
		bus_data <= 16'h1234;
		bus_address_load_low <= 1'b1;
		bus_address_load_high <= 1'b1;
		@(posedge clk);
		bus_address_load_low <= 1'b0;
		bus_address_load_high <= 1'b0;
		pulse(S_TCP);
		inhibit_address_increment <= 1'b1;
		pulse(S_TCP);
		@(negedge clk);
		chk(bus_address_q, 16'h1236);
		@(posedge clk);
		inhibit_address_increment <= 1'b0;
		// Clock enable low freezes the counter
		ce <= 1'b0;
		pulse(S_TCP);
		ce <= 1'b1;
		@(negedge clk);
		chk(bus_address_q, 16'h1236);
		@(posedge clk);
		sector(16'h40A3, 1'b0, 16'h40A4, 1'b0, 1'b0);
		sector(16'h40AB, 1'b1, 16'h40B0, 1'b1, 1'b0);
		sector(16'h40BB, 1'b1, 16'h40C0, 1'b1, 1'b1);
		file_done <= 1'b1;
		sector(16'h40DB, 1'b1, 16'h40E0, 1'b1, 1'b0);
		file_done <= 1'b0;
		pulse(S_INIT);
		@(negedge clk);
		chk(disk_address_q, 16'h0000);
		chk(bus_address_q, 16'h0000);
		@(posedge clk);
		$display("test registers and sectors done");

		// Fill until the path refuses more words, then drain it
		pulse(S_GCLR);
		func_write <= 1'b1;
		data_major <= 1'b1;
		pulse(S_NEWF);
		for (int i = 0; i < 6; i++) begin
			// Let the full flag reach the request before asking again
			repeat (3) @(posedge clk);
			wait_for(1);
			bus_data <= 16'hA5C0 + 16'(i);
			pulse(S_DSTR);
			pulse(S_TCP);
		end
		repeat (8) @(negedge clk);
		chk1(input_buffer_full_q, 1'b1);
		chk1(transfer_request_q, 1'b0);
		chk(bus_address_q, 16'h000C);
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			wait_for(2);
			chk(out_buffer_q, 16'hA5C0 + 16'(i));
			run_bits(1'b0, 5'h10, 16'h0000);
		end
		repeat (8) @(negedge clk);
		chk1(output_buffer_full_q, 1'b0);
		chk1(data_late_error_q, 1'b0);
		@(posedge clk);
		// Write-check draws from the empty output buffer
		func_write <= 1'b0;
		func_write_check <= 1'b1;
		run_bits(1'b0, 5'h01, 16'h0000);
		@(negedge clk);
		chk1(data_late_error_q, 1'b1);
		@(posedge clk);
		pulse(S_INIT);
		@(negedge clk);
		chk1(data_late_error_q, 1'b0);
		@(posedge clk);
		func_write_check <= 1'b0;
		$display("test write fill and drain done");

		for (int fm = 0; fm < 2; fm++) begin
			pulse(S_GCLR);
			func_read <= 1'b1;
			format_mode <= fm[0];
			data_major <= !fm[0];
			header_major <= fm[0];
			pulse(S_NEWF);
			run_bits(1'b1, 5'h10, 16'h3C96 ^ 16'(fm));
			wait_for(2);
			chk(out_buffer_q, 16'h3C96 ^ 16'(fm));
			wait_for(1);
			func_read <= 1'b0;
			func_read_check <= 1'b1;
			repeat (3) @(negedge clk);
			chk1(transfer_request_q, 1'b0);
			@(posedge clk);
			func_read <= 1'b1;
			func_read_check <= 1'b0;
			pulse(S_TCP);
			repeat (2) @(negedge clk);
			chk1(output_buffer_full_q, 1'b0);
			@(posedge clk);
			pulse(S_WCO);
			@(negedge clk);
			chk1(transfer_enable_q, 1'b0);
			@(posedge clk);
		end
		$display("test read and format read done");

		// Six words fill out buffer, file and in buffer; one more bit overruns
		pulse(S_GCLR);
		format_mode <= 1'b0;
		data_major <= 1'b1;
		header_major <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			run_bits(1'b1, 5'h10, 16'h0F0F);
		end
		@(negedge clk);
		chk1(data_late_error_q, 1'b0);
		@(posedge clk);
		run_bits(1'b1, 5'h01, 16'h0000);
		@(negedge clk);
		chk1(input_buffer_full_q, 1'b1);
		chk1(data_late_error_q, 1'b1);
		@(posedge clk);
		$display("test read overrun done");
		end_of_test();
	end
endmodule // ddp_data_path_tb

// *** tb/ddp_disk_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Far-side drive: serial read bits and write clock
// ****************************************
module ddp_disk_model (
	// Clock and commands
	input wire logic clk,
	input wire logic rd_go,
	input wire logic wr_go,
	input wire logic [4:0] nbits,
	input wire logic [15:0] rd_word,
	// Drive pins
	output logic drive_read_clock,
	output logic write_clock,
	output logic ser_rd_data,
	output logic busy
);
	logic rd;

	initial begin
		drive_read_clock = 1'b0;
		write_clock = 1'b0;
		ser_rd_data = 1'b0;
		busy = 1'b0;
		rd = 1'b0;
	end

	// Clocks stand still between frames; data idles at the inverse of its last bit
	always begin
		@(posedge clk);
		if (rd_go || wr_go) begin
			rd = rd_go;
			busy <= 1'b1;
			for (int i = 0; i < nbits; i++) begin
				if (rd) begin
					ser_rd_data <= rd_word[i];
				end
				// Data settles two clocks ahead of the pin edge so ser2_q already holds it when the edge is detected
				repeat (2) @(posedge clk);
				if (rd) begin
					drive_read_clock <= 1'b1;
				end else begin
					write_clock <= 1'b1;
				end
				repeat (3) @(posedge clk);
				drive_read_clock <= 1'b0;
				write_clock <= 1'b0;
				repeat (2) @(posedge clk);
			end
			ser_rd_data <= ~ser_rd_data;
			busy <= 1'b0;
		end
	end
endmodule // ddp_disk_model
